// [verilog/ccr_regs.svh]
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ***********************************************************************
// Command codes, 16 bits each, sent most significant byte first.
// ***********************************************************************
`define CCR_CMD_GET_TOFF 16'h2318
`define CCR_CMD_SET_ALT 16'h2427
`define CCR_CMD_GET_ALT 16'h2322
`define CCR_CMD_SET_PRESS 16'he000
`define CCR_CMD_RECAL 16'h362f
`define CCR_CMD_STOP 16'h3f86

// ***********************************************************************
// Reset values and fixed words.
// ***********************************************************************
`define CCR_ALT_RESET 16'h0000
`define CCR_PRESS_RESET 16'h0000
`define CCR_RECAL_FAIL 16'hffff
`define CCR_RECAL_BIAS 16'h8000
`define CCR_BASELINE_PPM 16'h0190
`define CCR_CRC_POLY 8'h31
`define CCR_CRC_INIT 8'hff

// ***********************************************************************
// Timing, in milliseconds, minutes and derived clock counts.
// ***********************************************************************
`define CCR_CLK_HZ 40000000
`define CCR_MS_CYCLES (`CCR_CLK_HZ / 1000)
`define CCR_T_EXEC_MS 1
`define CCR_T_RECAL_MS 400
`define CCR_T_STOP_MS 500
`define CCR_T_SETTLE_MIN 3
`define CCR_T_SETTLE_MS (`CCR_T_SETTLE_MIN * 60 * 1000)

`endif

// [verilog/ccr_pkg.sv]
`include "ccr_regs.svh"

package ccr_pkg;

   // ********************************************************************
   // Operations that the host user side may ask for.
   // ********************************************************************
   typedef enum logic [2:0] {
      CCR_OP_GET_TOFF,
      CCR_OP_SET_ALT,
      CCR_OP_GET_ALT,
      CCR_OP_SET_PRESS,
      CCR_OP_RECAL,
      CCR_OP_STOP
   } ccr_op_e;

   typedef logic [8:0] ccr_ms_t;

   // Checksum over one word, high byte first, poly x^8+x^5+x^4+1.
   function automatic logic [7:0] ccr_crc8(input logic [15:0] word);
      logic [7:0] crc;
      crc = `CCR_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (crc[7] ^ word[i]) begin
            crc = {crc[6:0], 1'b0} ^ `CCR_CRC_POLY;
         end else begin
            crc = {crc[6:0], 1'b0};
         end
      end
      return crc;
   endfunction : ccr_crc8

   // Longest execution time of a command, in milliseconds.
   function automatic ccr_ms_t ccr_exec_ms(input logic [15:0] code);
      ccr_ms_t ms;
      ms = 9'(`CCR_T_EXEC_MS);
      if (code == `CCR_CMD_RECAL) begin
         ms = 9'(`CCR_T_RECAL_MS);
      end else if (code == `CCR_CMD_STOP) begin
         ms = 9'(`CCR_T_STOP_MS);
      end
      return ms;
   endfunction : ccr_exec_ms

   // Commands that return a word and checksum.
   function automatic logic ccr_has_rsp(input logic [15:0] code);
      return (code == `CCR_CMD_GET_TOFF) || (code == `CCR_CMD_GET_ALT) ||
         (code == `CCR_CMD_RECAL);
   endfunction : ccr_has_rsp

   function automatic logic [15:0] ccr_op_code(input ccr_op_e op);
      logic [15:0] code;
      code = `CCR_CMD_STOP;
      unique case (op)
         CCR_OP_GET_TOFF: code = `CCR_CMD_GET_TOFF;
         CCR_OP_SET_ALT: code = `CCR_CMD_SET_ALT;
         CCR_OP_GET_ALT: code = `CCR_CMD_GET_ALT;
         CCR_OP_SET_PRESS: code = `CCR_CMD_SET_PRESS;
         CCR_OP_RECAL: code = `CCR_CMD_RECAL;
         CCR_OP_STOP: code = `CCR_CMD_STOP;
      endcase
      return code;
   endfunction : ccr_op_code

endpackage : ccr_pkg

// [verilog/ccr_link_if.sv]
// ***********************************************************************
// Word-level command link between host and sensor, one clock.
// ***********************************************************************
interface ccr_link_if (
   input wire logic clk_sys
);
   logic cmd_valid;
   logic [15:0] cmd_code;
   logic [15:0] par_word;
   logic [7:0] par_crc;
   logic rsp_read;
   logic busy;
   logic rsp_valid;
   logic [15:0] rsp_word;
   logic [7:0] rsp_crc;

   modport dev (
      input cmd_valid, cmd_code, par_word, par_crc, rsp_read,
      output busy, rsp_valid, rsp_word, rsp_crc
   );

   modport host (
      output cmd_valid, cmd_code, par_word, par_crc, rsp_read,
      input busy, rsp_valid, rsp_word, rsp_crc
   );
endinterface : ccr_link_if

// [verilog/ccr_dev.sv]
`include "ccr_regs.svh"

module ccr_dev #(
   parameter int MS_CYCLES = `CCR_MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic srst,
   ccr_link_if.dev lnk,
   input wire logic meas_active,
   input wire logic [15:0] co2_ppm,
   input wire logic [15:0] toff_word,
   output logic [15:0] altitude_m,
   output logic [15:0] pressure_word,
   output logic use_pressure,
   output logic [15:0] baseline_ppm,
   output logic stop_req,
   output logic crc_err
);

   // ********************************************************************
   // Millisecond tick.
   // ********************************************************************
   logic [15:0] ms_cnt_ff;
   logic ms_tick_ff;
   logic busy_ff;
   ccr_pkg::ccr_ms_t wait_ff;
   logic take;
   logic par_ok;
   logic rsp_pend_ff;
   logic rsp_valid_ff;
   logic [15:0] rsp_word_ff;
   logic [7:0] rsp_crc_ff;
   logic [15:0] alt_ff;
   logic [15:0] press_ff;
   logic use_press_ff;
   logic operated_ff;
   logic stop_ff;
   logic crc_err_ff;
   logic [15:0] base_ff;

   // The tick is free running, so a one millisecond wait ends anywhere
   // from one cycle to a full millisecond after the command is taken.
   always_ff @(posedge clk_sys) begin
      if (srst || ms_cnt_ff == 16'(MS_CYCLES - 1)) begin
         ms_cnt_ff <= 16'h0000;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= (ms_cnt_ff == 16'(MS_CYCLES - 1));
      end
   end

   // ********************************************************************
   // Command acceptance and execution time.
   // ********************************************************************
   // Commands offered while busy are ignored, not queued.
   assign take = lnk.cmd_valid && !busy_ff;
   assign par_ok = (lnk.par_crc == ccr_pkg::ccr_crc8(lnk.par_word));

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busy_ff <= 1'b0;
         wait_ff <= '0;
      end else if (take) begin
         busy_ff <= 1'b1;
         wait_ff <= ccr_pkg::ccr_exec_ms(lnk.cmd_code);
      end else if (busy_ff && ms_tick_ff) begin
         wait_ff <= wait_ff - 9'h001;
         if (wait_ff == 9'h001) begin
            busy_ff <= 1'b0;
         end
      end
   end

   // ********************************************************************
   // Response word; loaded when the command is taken, marked valid only once execution time has run out.
   // ********************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_pend_ff <= 1'b0;
         rsp_word_ff <= 16'h0000;
         rsp_crc_ff <= 8'h00;
      end else if (take) begin
         rsp_pend_ff <= 1'b0;
         unique case (lnk.cmd_code)
            `CCR_CMD_GET_TOFF: begin
               rsp_pend_ff <= 1'b1;
               rsp_word_ff <= toff_word;
               rsp_crc_ff <= ccr_pkg::ccr_crc8(toff_word);
            end
            `CCR_CMD_GET_ALT: begin
               rsp_pend_ff <= !meas_active;
               rsp_word_ff <= alt_ff;
               rsp_crc_ff <= ccr_pkg::ccr_crc8(alt_ff);
            end
            `CCR_CMD_RECAL: begin
               rsp_pend_ff <= par_ok && !meas_active;
               if (operated_ff) begin
                  rsp_word_ff <= lnk.par_word - co2_ppm + `CCR_RECAL_BIAS;
                  rsp_crc_ff <= ccr_pkg::ccr_crc8(
                     lnk.par_word - co2_ppm + `CCR_RECAL_BIAS);
               end else begin
                  rsp_word_ff <= `CCR_RECAL_FAIL;
                  rsp_crc_ff <= ccr_pkg::ccr_crc8(`CCR_RECAL_FAIL);
               end
            end
            default: begin
               rsp_pend_ff <= 1'b0;
            end
         endcase
      end
   end

   // Valid rises as busy falls and stays until read or the next command.
   always_ff @(posedge clk_sys) begin
      if (srst || take || lnk.rsp_read) begin
         rsp_valid_ff <= 1'b0;
      end else if (busy_ff && ms_tick_ff && wait_ff == 9'h001) begin
         rsp_valid_ff <= rsp_pend_ff;
      end
   end

   // ********************************************************************
   // Settings held in volatile flops; commit to storage lies elsewhere.
   // ********************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         alt_ff <= `CCR_ALT_RESET;
      end else if (take && lnk.cmd_code == `CCR_CMD_SET_ALT && par_ok &&
                   !meas_active) begin
         alt_ff <= lnk.par_word;
      end
   end

   // Pressure is taken whether or not measurement runs, and once written
   // it replaces altitude as the compensation source.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         press_ff <= `CCR_PRESS_RESET;
         use_press_ff <= 1'b0;
      end else if (take && lnk.cmd_code == `CCR_CMD_SET_PRESS && par_ok) begin
         press_ff <= lnk.par_word;
         use_press_ff <= 1'b1;
      end
   end

   // Any measurement since reset makes recalibration possible.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         operated_ff <= 1'b0;
      end else if (meas_active) begin
         operated_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stop_ff <= 1'b0;
         crc_err_ff <= 1'b0;
      end else begin
         stop_ff <= take && lnk.cmd_code == `CCR_CMD_STOP;
         crc_err_ff <= take && !par_ok &&
            (lnk.cmd_code == `CCR_CMD_SET_ALT ||
             lnk.cmd_code == `CCR_CMD_SET_PRESS ||
             lnk.cmd_code == `CCR_CMD_RECAL);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         base_ff <= `CCR_BASELINE_PPM;
      end
   end

   assign lnk.busy = busy_ff;
   assign lnk.rsp_valid = rsp_valid_ff;
   assign lnk.rsp_word = rsp_word_ff;
   assign lnk.rsp_crc = rsp_crc_ff;
   assign altitude_m = alt_ff;
   assign pressure_word = press_ff;
   assign use_pressure = use_press_ff;
   assign baseline_ppm = base_ff;
   assign stop_req = stop_ff;
   assign crc_err = crc_err_ff;

endmodule : ccr_dev

// [verilog/ccr_host.sv]
`include "ccr_regs.svh"

module ccr_host #(
   parameter int MS_CYCLES = `CCR_MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic srst,
   ccr_link_if.host lnk,
   input wire logic req_valid,
   input wire ccr_pkg::ccr_op_e req_op,
   input wire logic [15:0] req_word,
   input wire logic dev_running,
   output logic req_ready,
   output logic done,
   output logic [15:0] rsp_word,
   output logic rsp_ok,
   output logic refused,
   output logic restart_req
);

   typedef enum logic [2:0] {
      CCR_H_IDLE, CCR_H_STOP, CCR_H_SEND, CCR_H_WAIT, CCR_H_READ
   } ccr_hst_e;

   ccr_hst_e st_ff;
   logic [15:0] ms_cnt_ff;
   logic ms_tick_ff;
   logic [17:0] run_ms_ff;
   logic settled_ff;
   ccr_pkg::ccr_ms_t wait_ff;
   logic [15:0] code_ff;
   logic [15:0] word_ff;
   logic stopped_ff;
   logic after_stop_ff;
   logic cmd_valid_ff;
   logic [15:0] cmd_code_ff;
   logic [15:0] par_word_ff;
   logic [7:0] par_crc_ff;
   logic rsp_read_ff;
   logic done_ff;
   logic [15:0] rsp_word_ff;
   logic rsp_ok_ff;
   logic refused_ff;
   logic restart_ff;
   logic needs_idle;
   logic ready_ff;

   // ********************************************************************
   // Millisecond tick and settling timer.
   // ********************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst || ms_cnt_ff == 16'(MS_CYCLES - 1)) begin
         ms_cnt_ff <= 16'h0000;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= (ms_cnt_ff == 16'(MS_CYCLES - 1));
      end
   end

   // Settled latches after a long enough run and survives the stop that
   // must precede recalibration; a finished recalibration clears it.
   always_ff @(posedge clk_sys) begin
      if (srst || !dev_running) begin
         run_ms_ff <= '0;
      end else if (ms_tick_ff && run_ms_ff <= 18'(`CCR_T_SETTLE_MS)) begin
         run_ms_ff <= run_ms_ff + 18'h00001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || (done_ff && code_ff == `CCR_CMD_RECAL)) begin
         settled_ff <= 1'b0;
      end else if (run_ms_ff > 18'(`CCR_T_SETTLE_MS)) begin
         settled_ff <= 1'b1;
      end
   end

   // ********************************************************************
   // Sequencer.
   // ********************************************************************
   assign needs_idle = (req_op == ccr_pkg::CCR_OP_SET_ALT) ||
      (req_op == ccr_pkg::CCR_OP_GET_ALT) ||
      (req_op == ccr_pkg::CCR_OP_GET_TOFF) ||
      (req_op == ccr_pkg::CCR_OP_RECAL);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff <= CCR_H_IDLE;
         code_ff <= `CCR_CMD_STOP;
         word_ff <= 16'h0000;
         stopped_ff <= 1'b0;
         after_stop_ff <= 1'b0;
         wait_ff <= '0;
         cmd_valid_ff <= 1'b0;
         cmd_code_ff <= 16'h0000;
         par_word_ff <= 16'h0000;
         par_crc_ff <= 8'h00;
         rsp_read_ff <= 1'b0;
         done_ff <= 1'b0;
         rsp_word_ff <= 16'h0000;
         rsp_ok_ff <= 1'b0;
         refused_ff <= 1'b0;
         restart_ff <= 1'b0;
         ready_ff <= 1'b1;
      end else begin
         cmd_valid_ff <= 1'b0;
         rsp_read_ff <= 1'b0;
         done_ff <= 1'b0;
         refused_ff <= 1'b0;
         restart_ff <= 1'b0;
         unique case (st_ff)
            CCR_H_IDLE: begin
               after_stop_ff <= 1'b0;
               if (req_valid) begin
                  code_ff <= ccr_pkg::ccr_op_code(req_op);
                  word_ff <= req_word;
                  stopped_ff <= needs_idle && dev_running;
                  if (req_op == ccr_pkg::CCR_OP_RECAL && !settled_ff) begin
                     refused_ff <= 1'b1;
                  end else if (needs_idle && dev_running) begin
                     ready_ff <= 1'b0;
                     st_ff <= CCR_H_STOP;
                  end else begin
                     ready_ff <= 1'b0;
                     st_ff <= CCR_H_SEND;
                  end
               end
            end
            CCR_H_STOP: begin
               if (!lnk.busy) begin
                  cmd_valid_ff <= 1'b1;
                  cmd_code_ff <= `CCR_CMD_STOP;
                  wait_ff <= ccr_pkg::ccr_exec_ms(`CCR_CMD_STOP) + 9'h001;
                  after_stop_ff <= 1'b1;
                  st_ff <= CCR_H_WAIT;
               end
            end
            CCR_H_SEND: begin
               if (!lnk.busy) begin
                  cmd_valid_ff <= 1'b1;
                  cmd_code_ff <= code_ff;
                  par_word_ff <= word_ff;
                  par_crc_ff <= ccr_pkg::ccr_crc8(word_ff);
                  wait_ff <= ccr_pkg::ccr_exec_ms(code_ff) + 9'h001;
                  after_stop_ff <= 1'b0;
                  st_ff <= CCR_H_WAIT;
               end
            end
            CCR_H_WAIT: begin
               // One extra tick makes the wait at least the full time.
               if (ms_tick_ff && wait_ff != '0) begin
                  wait_ff <= wait_ff - 9'h001;
               end else if (wait_ff == '0 && !lnk.busy) begin
                  if (after_stop_ff) begin
                     st_ff <= CCR_H_SEND;
                  end else if (ccr_pkg::ccr_has_rsp(code_ff)) begin
                     st_ff <= CCR_H_READ;
                  end else begin
                     done_ff <= 1'b1;
                     restart_ff <= stopped_ff;
                     ready_ff <= 1'b1;
                     st_ff <= CCR_H_IDLE;
                  end
               end
            end
            CCR_H_READ: begin
               // A missing answer ends the request with rsp_ok low.
               rsp_read_ff <= lnk.rsp_valid;
               rsp_word_ff <= lnk.rsp_word;
               rsp_ok_ff <= lnk.rsp_valid &&
                  lnk.rsp_crc == ccr_pkg::ccr_crc8(lnk.rsp_word);
               done_ff <= 1'b1;
               restart_ff <= stopped_ff;
               ready_ff <= 1'b1;
               st_ff <= CCR_H_IDLE;
            end
         endcase
      end
   end

   assign lnk.cmd_valid = cmd_valid_ff;
   assign lnk.cmd_code = cmd_code_ff;
   assign lnk.par_word = par_word_ff;
   assign lnk.par_crc = par_crc_ff;
   assign lnk.rsp_read = rsp_read_ff;
   assign req_ready = ready_ff;
   assign done = done_ff;
   assign rsp_word = rsp_word_ff;
   assign rsp_ok = rsp_ok_ff;
   assign refused = refused_ff;
   assign restart_req = restart_ff;

endmodule : ccr_host

// [bench/ccr_link_assertions.sv]
// ***********************************************************************
// Link checker: timing, checksums and response rules.
// ***********************************************************************
module ccr_link_assertions #(
   parameter int MS_CYCLES = 40000
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic [15:0] par_word,
   input wire logic [7:0] par_crc,
   input wire logic rsp_read,
   input wire logic busy,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_word,
   input wire logic [7:0] rsp_crc
);
   logic [15:0] last_ff;
   int bcnt_ff;

   // Own checksum, so a shared slip cannot hide itself.
   function automatic logic [7:0] chk_crc(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      end
      return c;
   endfunction : chk_crc

   // Last accepted code and length of the running busy period.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         last_ff <= 16'h0000;
         bcnt_ff <= 0;
      end else begin
         if (cmd_valid && !busy) begin
            last_ff <= cmd_code;
         end
         bcnt_ff <= busy ? bcnt_ff + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   sequence s_take;
      cmd_valid && !busy;
   endsequence

   sequence s_end(logic [15:0] code);
      $fell(busy) && last_ff == code;
   endsequence

   AST_TAKE_BUSY: assert property (s_take |=> busy)
      else $error("Busy did not follow an accepted command.");
   AST_HOST_WAITS: assert property (busy |-> !cmd_valid)
      else $error("Command offered while busy.");
   AST_PAR_CRC:
      assert property (cmd_valid && (cmd_code == 16'h2427 ||
         cmd_code == 16'he000) |-> par_crc == chk_crc(par_word))
      else $error("Parameter checksum wrong.");
   AST_RSP_CRC:
      assert property (rsp_valid |-> rsp_crc == chk_crc(rsp_word))
      else $error("Response checksum wrong.");
   AST_ONE_MS:
      assert property ($fell(busy) && last_ff != 16'h362f &&
         last_ff != 16'h3f86 |-> bcnt_ff <= MS_CYCLES + 1)
      else $error("Short command ran past one millisecond.");
   AST_STOP_WAIT:
      assert property (s_end(16'h3f86) |-> bcnt_ff >= 499 * MS_CYCLES &&
         bcnt_ff <= 500 * MS_CYCLES + 1)
      else $error("Stop blocking time wrong.");
   AST_NO_RSP_SET:
      assert property (s_end(16'h2427) or s_end(16'he000) |-> !rsp_valid)
      else $error("Write command gave a response.");
   AST_RSP_SOURCE:
      assert property ($rose(rsp_valid) |-> $fell(busy) &&
         (last_ff == 16'h2318 || last_ff == 16'h2322 ||
         last_ff == 16'h362f))
      else $error("Response without a reading command.");
   AST_RSP_HOLDS:
      assert property (rsp_valid && !rsp_read && !cmd_valid |=>
         rsp_valid && $stable(rsp_word))
      else $error("Response dropped before it was read.");
   AST_READ_CLEARS: assert property (rsp_read |=> !rsp_valid)
      else $error("Response stayed after read.");
endmodule : ccr_link_assertions

// [bench/tb_ccr.sv]
// ***********************************************************************
// Host and sensor ends joined; a second sensor end is driven directly.
// ***********************************************************************
module tb_ccr;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 20;
   logic clk_sys;
   logic srst = 1'b1;
   logic meas = 1'b0;
   logic meas2 = 1'b0;
   logic run = 1'b0;
   logic req_valid = 1'b0;
   ccr_pkg::ccr_op_e req_op = ccr_pkg::CCR_OP_GET_ALT;
   logic [15:0] req_word = 16'h0000;
   logic [15:0] co2 = 16'h0212;
   logic [15:0] toff = 16'h0912;
   logic [15:0] alt, alt2, press, base, rsp_word, cap_code, cap_par;
   logic [15:0] cap_crc, cap_rcrc, rw;
   logic [7:0] rc;
   logic use_p, stop_req, crc_err, crc_err2, req_ready, done, rsp_ok;
   logic refused, restart_req, hd, hr, hx, ce, rv;
   int err_count = 0;
   int checked = 0;
   int stops = 0;
   int cyc = 0;
   int dn;

   ccr_link_if lnk (.clk_sys(clk_sys));
   ccr_link_if lnk2 (.clk_sys(clk_sys));
   ccr_dev #(.MS_CYCLES(MS)) ccr_dev_inst (.clk_sys(clk_sys),
      .srst(srst), .lnk(lnk), .meas_active(meas), .co2_ppm(co2),
      .toff_word(toff), .altitude_m(alt), .pressure_word(press),
      .use_pressure(use_p), .baseline_ppm(base), .stop_req(stop_req),
      .crc_err(crc_err));
   ccr_host #(.MS_CYCLES(MS)) ccr_host_inst (.clk_sys(clk_sys),
      .srst(srst), .lnk(lnk), .req_valid(req_valid), .req_op(req_op),
      .req_word(req_word), .dev_running(run), .req_ready(req_ready),
      .done(done), .rsp_word(rsp_word), .rsp_ok(rsp_ok),
      .refused(refused), .restart_req(restart_req));
   ccr_dev #(.MS_CYCLES(MS)) ccr_dev_inst2 (.clk_sys(clk_sys),
      .srst(srst), .lnk(lnk2), .meas_active(meas2), .co2_ppm(co2),
      .toff_word(toff), .altitude_m(alt2), .pressure_word(),
      .use_pressure(), .baseline_ppm(), .stop_req(),
      .crc_err(crc_err2));
   ccr_link_assertions #(.MS_CYCLES(MS)) ccr_link_assertions_inst (
      .clk_sys(clk_sys), .srst(srst), .cmd_valid(lnk.cmd_valid),
      .cmd_code(lnk.cmd_code), .par_word(lnk.par_word),
      .par_crc(lnk.par_crc), .rsp_read(lnk.rsp_read), .busy(lnk.busy),
      .rsp_valid(lnk.rsp_valid), .rsp_word(lnk.rsp_word),
      .rsp_crc(lnk.rsp_crc));

   // Clock at 40 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Wire watch; a stop ends the sensor's measuring as the real one would.
   always @(posedge clk_sys) begin
      cyc++;
      if (lnk.cmd_valid && !lnk.busy) begin
         cap_code <= lnk.cmd_code;
         cap_par <= lnk.par_word;
         cap_crc <= {8'h00, lnk.par_crc};
      end
      if (lnk.rsp_valid) begin
         cap_rcrc <= {8'h00, lnk.rsp_crc};
      end
      if (stop_req) begin
         meas <= 1'b0;
         stops++;
      end
      if (cyc == 60000) begin
         err_count++;
         $display("[ERR] run time expected end seen hang");
         print_verdict();
      end
   end

   task automatic cmp(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic cmpb(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : cmpb

   // One user request; waits for done or refused under a bound.
   task automatic host_req(input ccr_pkg::ccr_op_e op,
         input logic [15:0] w);
      int n;
      n = 0;
      req_op <= op;
      req_word <= w;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (done !== 1'b1 && refused !== 1'b1 && n < 12000);
      chk_limit(n);
      hd = done;
      hr = refused;
      hx = restart_req;
      @(posedge clk_sys);
   endtask : host_req

   // Direct command to the second sensor; released data shows inverted.
   task automatic dev_cmd(input logic [15:0] code, input logic [15:0] w,
         input logic [7:0] c);
      dn = 0;
      lnk2.cmd_code <= code;
      lnk2.par_word <= w;
      lnk2.par_crc <= c;
      lnk2.cmd_valid <= 1'b1;
      @(posedge clk_sys);
      lnk2.cmd_valid <= 1'b0;
      lnk2.par_word <= ~w;
      do begin
         @(posedge clk_sys);
         dn++;
         if (dn == 1) begin
            ce = crc_err2;
         end
      end while (lnk2.busy !== 1'b0 && dn < 12000);
      chk_limit(dn);
      rv = lnk2.rsp_valid;
      rw = lnk2.rsp_word;
      rc = lnk2.rsp_crc;
      lnk2.rsp_read <= rv;
      @(posedge clk_sys);
      lnk2.rsp_read <= 1'b0;
   endtask : dev_cmd

   task automatic t_basic;
      cmp("altitude", 16'h0000, alt);
      cmp("baseline", 16'h0190, base);
      host_req(ccr_pkg::CCR_OP_GET_ALT, 16'h0000);
      cmp("alt word", 16'h0000, rsp_word);
      cmp("alt crc", 16'h0081, cap_rcrc);
      host_req(ccr_pkg::CCR_OP_GET_TOFF, 16'h0000);
      cmp("offset", 16'h0912, rsp_word);
      cmp("offset crc", 16'h0063, cap_rcrc);
      cmpb("offset ok", 1'b1, rsp_ok);
      $display("basic reads finished");
   endtask : t_basic

   task automatic t_alt;
      host_req(ccr_pkg::CCR_OP_SET_ALT, 16'h044c);
      cmp("wire code", 16'h2427, cap_code);
      cmp("wire word", 16'h044c, cap_par);
      cmp("wire crc", 16'h0042, cap_crc);
      cmp("stored", 16'h044c, alt);
      host_req(ccr_pkg::CCR_OP_GET_ALT, 16'h0000);
      cmp("readback", 16'h044c, rsp_word);
      $display("altitude test finished");
   endtask : t_alt

   // Pressure goes in while measuring; then a read forces a stop.
   task automatic t_run;
      meas <= 1'b1;
      run <= 1'b1;
      host_req(ccr_pkg::CCR_OP_SET_PRESS, 16'h03db);
      cmp("press code", 16'he000, cap_code);
      cmp("press crc", 16'h0042, cap_crc);
      cmp("pressure", 16'h03db, press);
      cmpb("press mode", 1'b1, use_p);
      cmp("no stop", 16'h0000, 16'(stops));
      host_req(ccr_pkg::CCR_OP_GET_ALT, 16'h0000);
      cmp("one stop", 16'h0001, 16'(stops));
      cmp("idle read", 16'h044c, rsp_word);
      cmpb("restart", 1'b1, hx);
      run <= 1'b0;
      host_req(ccr_pkg::CCR_OP_RECAL, 16'h01e0);
      cmpb("refused", 1'b1, hr);
      cmpb("no done", 1'b0, hd);
      $display("running test finished");
   endtask : t_run

   // Second sensor: bad checksum, failed and good recalibration.
   task automatic t_direct;
      dev_cmd(16'h2427, 16'h079e, 8'h08);
      cmpb("crc flag", 1'b1, ce);
      cmp("kept alt", 16'h0000, alt2);
      dev_cmd(16'h2427, 16'h079e, 8'h09);
      cmpb("crc clean", 1'b0, ce);
      cmp("alt2", 16'h079e, alt2);
      cmpb("no answer", 1'b0, rv);
      dev_cmd(16'h362f, 16'h01e0, 8'hb4);
      cmp("fail word", 16'hffff, rw);
      meas2 <= 1'b1;
      dev_cmd(16'h2322, 16'h0000, 8'h81);
      cmpb("busy read", 1'b0, rv);
      meas2 <= 1'b0;
      dev_cmd(16'h362f, 16'h01e0, 8'hb5);
      cmpb("recal flag", 1'b1, ce);
      cmpb("bad recal", 1'b0, rv);
      dev_cmd(16'h362f, 16'h01e0, 8'hb4);
      cmp("correction", 16'h7fce, rw);
      cmp("corr crc", 16'h007b, {8'h00, rc});
      cmpb("wait", 1'b1, dn > 399 * MS && dn <= 400 * MS + 2);
      $display("direct test finished");
   endtask : t_direct

   // A wait that runs out is a mismatch and ends the run at once.
   task automatic chk_limit(input int n);
      if (n >= 12000) begin
         err_count++;
         $display("[ERR] wait limit expected below 12000 seen %0d", n);
         print_verdict();
      end
   endtask : chk_limit

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // Reset for five cycles, then the scenarios in turn.
   initial begin
      lnk2.cmd_valid = 1'b0;
      lnk2.cmd_code = 16'h0000;
      lnk2.par_word = 16'h0000;
      lnk2.par_crc = 8'h00;
      lnk2.rsp_read = 1'b0;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      t_basic();
      t_alt();
      t_run();
      t_direct();
      print_verdict();
   end
endmodule : tb_ccr
